// ===== sbr_cfg.svh
// Purpose: named constants for the supervisor battery/reset logic
// Assumes: 100 MHz clk, one free-running millisecond tick
// Notes:   times stay in their own unit; counts are derived
`ifndef SBR_CFG_SVH
`define SBR_CFG_SVH

`define SBR_CLK_MHZ         100
`define SBR_CLK_NS          10
`define SBR_TICK_US         1000
`define SBR_TEST_WIN_MS     1235
`define SBR_TEST_DAY_H      24
`define SBR_RST_MS          145
`define SBR_SEAL_HV_NS      3000
`define SBR_SEC_PER_H       3600

`define SBR_TICK_CYC        (`SBR_TICK_US * `SBR_CLK_MHZ)
`define SBR_TEST_TICKS      ((`SBR_TEST_WIN_MS * 1000) / `SBR_TICK_US)
`define SBR_DAY_TICKS       (`SBR_TEST_DAY_H * `SBR_SEC_PER_H * (1000000 / `SBR_TICK_US))
`define SBR_RST_TICKS       ((`SBR_RST_MS * 1000 + `SBR_TICK_US - 1) / `SBR_TICK_US)
`define SBR_SEAL_HV_CYC     ((`SBR_SEAL_HV_NS + `SBR_CLK_NS - 1) / `SBR_CLK_NS)

`define SBR_OFS_CTRL        12'h000
`define SBR_OFS_STATUS      12'h004
`define SBR_CTRL_TEST_NOW   0
`define SBR_ST_ON_BACKUP_CELL_INPUT      0
`define SBR_ST_BACKUP_CELL_INPUT_GOOD    1
`define SBR_ST_TESTING      2
`define SBR_ST_SEALED       3
`define SBR_ST_RESET        4
`define SBR_ST_PFAIL_N      5
`define SBR_ST_REARM        6

`endif

// ===== sbr_pkg.sv
// Purpose: shared types of the supervisor battery/reset logic
// Assumes: APB with 12-bit byte address and 32-bit data
// Notes:   sense bits are comparator results, high = above threshold, except outRailLow (high = rail low)
`default_nettype none
package sbr_pkg;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } sbr_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } sbr_apb_rsp_t;

    typedef struct packed {
        logic vccAboveRst;
        logic vccAboveBatt;
        logic cellAboveTest;
        logic powerFailSense;
        logic manualResetN;
        logic manualResetHv;
        logic outRailLow;
    } sbr_sense_t;

    typedef enum logic [1:0] {
        TS_IDLE,
        TS_TEST,
        TS_WAIT
    } sbr_test_state_t;

endpackage
`default_nettype wire

// ===== sbr_battery_reset.sv
// Purpose: battery test scheduler, freshness seal, reset and status flags
// Assumes: comparator results arrive as digital levels on sense
// Notes:   APB slave: ctrl at 0x000, status at 0x004, others error
// Function
// - test battery 1.235s when supply appears
// - repeat test every 24 hours
// - load battery, check above 2.6V
// - weak battery drives good flag low
// - load drive high exactly during window
// - backup mode: no test, good low
// - first supply rise sets seal latch
// - sealed, supply loss switches rail to cell
// - reset below threshold, hold 145ms after
// - manual reset low asserts reset
// - watchdog timeout gives reset pulse
// - reset polarity is build parameter
// - power-fail flag low below threshold
// - power-fail flag independent of reset
// - on-battery flag high in backup mode
// - supply above threshold: never backup mode
// - backup needs supply below threshold and cell
// - hold reset 145ms after manual release
`include "sbr_cfg.svh"
`default_nettype none
module sbr_battery_reset #(
    parameter int unsigned TICK_CYC     = `SBR_TICK_CYC,
    parameter int unsigned TEST_TICKS   = `SBR_TEST_TICKS,
    parameter int unsigned DAY_TICKS    = `SBR_DAY_TICKS,
    parameter int unsigned RST_TICKS    = `SBR_RST_TICKS,
    parameter bit          RST_HIGH     = 1'b0,
    parameter bit          WDT_PULSES   = 1'b0,
    parameter bit          HAS_TEST_OUT = 1'b1
) (
    input  wire logic                clk,
    input  wire logic                rstn,
    input  wire sbr_pkg::sbr_apb_req_t apbReq,
    output var  sbr_pkg::sbr_apb_rsp_t apbRsp,
    input  wire sbr_pkg::sbr_sense_t sense,
    input  wire logic                watchdogTimeout,
    output logic                     resetOut,
    output logic                     batteryGoodFlag,
    output logic                     batteryTestLoadDrive,
    output logic                     powerFailFlagN,
    output logic                     onBatteryFlag,
    output logic                     railOnCell
);
    import sbr_pkg::*;

    localparam int unsigned SW = $bits(sbr_sense_t);

    sbr_sense_t      syncA_q;
    sbr_sense_t      syncB_q;
    logic [16:0]     tickCnt_q;
    logic            tick_q;
    sbr_test_state_t testState_q;
    logic [31:0]     winCnt_q;
    logic [31:0]     dayCnt_q;
    logic            fail_q;
    logic            vccOkPrev_q;
    logic            sealed_q;
    logic            rearm_q;
    logic [8:0]      hvCnt_q;
    logic [15:0]     rstCnt_q;
    logic            rstAsserted_q;
    logic            testNow_q;
    logic            vccOk;
    logic            vccRise;
    logic            backupMode;
    logic            rstTrig;
    logic            winEnd;
    logic            dayEnd;
    logic            apbWr;
    logic            apbAcc;
    logic [31:0]     statusWord;

    // two-flop synchroniser, first stage feeds only the second
    generate
        for (genvar i = 0; i < SW; i++) begin : g_sync
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    syncA_q[i] <= 1'b0;
                    syncB_q[i] <= 1'b0;
                end else begin
                    syncA_q[i] <= sense[i];
                    syncB_q[i] <= syncA_q[i];
                end
            end
        end
    endgenerate

    assign vccOk      = syncB_q.vccAboveRst;
    assign vccRise    = vccOk && !vccOkPrev_q;
    // backup only below reset threshold and below cell, once sealed
    assign backupMode = !vccOk && !syncB_q.vccAboveBatt && sealed_q;

    // free-running millisecond time base
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tickCnt_q <= 17'h00000;
            tick_q    <= 1'b0;
        end else if (tickCnt_q == 17'(TICK_CYC - 1)) begin
            tickCnt_q <= 17'h00000;
            tick_q    <= 1'b1;
        end else begin
            tickCnt_q <= tickCnt_q + 17'h00001;
            tick_q    <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            vccOkPrev_q <= 1'b0;
        end else begin
            vccOkPrev_q <= vccOk;
        end
    end

    assign winEnd = tick_q && (winCnt_q == 32'(TEST_TICKS - 1));
    assign dayEnd = tick_q && (dayCnt_q == 32'(DAY_TICKS - 1));

    // test scheduler
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            testState_q <= TS_IDLE;
            winCnt_q    <= 32'h00000000;
            dayCnt_q    <= 32'h00000000;
        end else if (!vccOk || backupMode) begin
            testState_q <= TS_IDLE;
            winCnt_q    <= 32'h00000000;
            dayCnt_q    <= 32'h00000000;
        end else if (vccRise) begin
            testState_q <= TS_TEST;
            winCnt_q    <= 32'h00000000;
            dayCnt_q    <= 32'h00000000;
        end else begin
            unique case (testState_q)
                TS_IDLE: begin
                    testState_q <= TS_TEST;
                    winCnt_q    <= 32'h00000000;
                    dayCnt_q    <= 32'h00000000;
                end
                TS_TEST: begin
                    if (winEnd) begin
                        testState_q <= TS_WAIT;
                    end
                    if (tick_q) begin
                        winCnt_q <= winCnt_q + 32'h00000001;
                        dayCnt_q <= dayCnt_q + 32'h00000001;
                    end
                end
                TS_WAIT: begin
                    if (dayEnd || testNow_q) begin
                        testState_q <= TS_TEST;
                        winCnt_q    <= 32'h00000000;
                        dayCnt_q    <= 32'h00000000;
                    end else if (tick_q) begin
                        dayCnt_q <= dayCnt_q + 32'h00000001;
                    end
                end
            endcase
        end
    end

    // any sample below 2.6V inside the window marks the cell weak
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fail_q <= 1'b0;
        end else if (testState_q != TS_TEST) begin
            fail_q <= 1'b0;
        end else if (!syncB_q.cellAboveTest) begin
            fail_q <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            batteryGoodFlag <= 1'b0;
        end else if (backupMode) begin
            batteryGoodFlag <= 1'b0;
        end else if (testState_q == TS_TEST && winEnd) begin
            batteryGoodFlag <= !fail_q && syncB_q.cellAboveTest;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            batteryTestLoadDrive <= 1'b0;
        end else begin
            // dropped at once when the supply goes, not a cycle late
            batteryTestLoadDrive <= HAS_TEST_OUT && (testState_q == TS_TEST)
                                    && vccOk;
        end
    end

    // freshness seal and its re-arm sequence
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hvCnt_q <= 9'h000;
        end else if (vccOk || !syncB_q.manualResetHv) begin
            hvCnt_q <= 9'h000;
        end else if (hvCnt_q != 9'(`SBR_SEAL_HV_CYC)) begin
            hvCnt_q <= hvCnt_q + 9'h001;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sealed_q <= 1'b0;
            rearm_q  <= 1'b0;
        end else if (vccOk) begin
            sealed_q <= 1'b1;
            rearm_q  <= 1'b0;
        end else if (rearm_q && syncB_q.outRailLow) begin
            sealed_q <= 1'b0;
            rearm_q  <= 1'b0;
        end else if (sealed_q && hvCnt_q == 9'(`SBR_SEAL_HV_CYC)) begin
            rearm_q  <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            onBatteryFlag <= 1'b0;
            railOnCell    <= 1'b0;
        end else begin
            onBatteryFlag <= backupMode;
            railOnCell    <= backupMode;
        end
    end

    // reset generator with minimum timeout
    assign rstTrig = !vccOk || !syncB_q.manualResetN
                     || (WDT_PULSES && watchdogTimeout);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rstCnt_q <= 16'(RST_TICKS + 1);
        end else if (rstTrig) begin
            rstCnt_q <= 16'(RST_TICKS + 1);
        end else if (tick_q && rstCnt_q != 16'h0000) begin
            rstCnt_q <= rstCnt_q - 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rstAsserted_q <= 1'b1;
            resetOut      <= RST_HIGH;
        end else begin
            rstAsserted_q <= rstTrig || (rstCnt_q != 16'h0000);
            resetOut      <= RST_HIGH ? rstAsserted_q : !rstAsserted_q;
        end
    end

    // power-fail path touches nothing of the reset logic
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            powerFailFlagN <= 1'b0;
        end else begin
            powerFailFlagN <= syncB_q.powerFailSense;
        end
    end

    // APB slave, zero wait states
    assign apbAcc = apbReq.psel && apbReq.penable;
    assign apbWr  = apbAcc && apbReq.pwrite;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            testNow_q <= 1'b0;
        end else begin
            testNow_q <= apbWr && (apbReq.paddr == `SBR_OFS_CTRL)
                         && apbReq.pwdata[`SBR_CTRL_TEST_NOW];
        end
    end

    always_comb begin
        statusWord                    = 32'h00000000;
        statusWord[`SBR_ST_ON_BACKUP_CELL_INPUT]   = onBatteryFlag;
        statusWord[`SBR_ST_BACKUP_CELL_INPUT_GOOD] = batteryGoodFlag;
        statusWord[`SBR_ST_TESTING]   = (testState_q == TS_TEST);
        statusWord[`SBR_ST_SEALED]    = sealed_q;
        statusWord[`SBR_ST_RESET]     = rstAsserted_q;
        statusWord[`SBR_ST_PFAIL_N]   = powerFailFlagN;
        statusWord[`SBR_ST_REARM]     = rearm_q;
    end

    always_comb begin
        apbRsp.pready  = 1'b1;
        apbRsp.pslverr = 1'b0;
        apbRsp.prdata  = 32'h00000000;
        if (apbReq.paddr == `SBR_OFS_STATUS) begin
            apbRsp.pslverr = apbAcc && apbReq.pwrite;
            if (!apbReq.pwrite) begin
                apbRsp.prdata = statusWord;
            end
        end else if (apbReq.paddr != `SBR_OFS_CTRL) begin
            apbRsp.pslverr = apbAcc;
        end
    end

    // checks: battery test and flags
    a_backup_cell_input_mode_good: assert property (@(posedge clk) disable iff (!rstn)
        onBatteryFlag |-> !batteryGoodFlag)
        else $error("good flag high on battery");
    a_backup_cell_input_mode_load: assert property (@(posedge clk) disable iff (!rstn)
        onBatteryFlag |-> ##1 !batteryTestLoadDrive)
        else $error("load on in backup");
    a_test_start: assert property (@(posedge clk) disable iff (!rstn)
        (vccRise && !backupMode) |-> ##2 batteryTestLoadDrive == HAS_TEST_OUT)
        else $error("no test on supply");
    a_load_window: assert property (@(posedge clk) disable iff (!rstn)
        $rose(batteryTestLoadDrive) |-> $past(testState_q == TS_TEST))
        else $error("load outside window");
    a_weak_cell: assert property (@(posedge clk) disable iff (!rstn)
        (testState_q == TS_TEST && winEnd && fail_q && !backupMode) |=> !batteryGoodFlag)
        else $error("weak cell not flagged");
    a_good_needs_test: assert property (@(posedge clk) disable iff (!rstn)
        $rose(batteryGoodFlag) |-> $past(testState_q == TS_TEST))
        else $error("good flag set outside test");
    a_pfail_track: assert property (@(posedge clk) disable iff (!rstn)
        !sense.powerFailSense |-> ##3 !powerFailFlagN)
        else $error("power-fail flag missed");

    // checks: reset generator
    a_vcc_low_reset: assert property (@(posedge clk) disable iff (!rstn)
        !vccOk |-> ##2 (resetOut == RST_HIGH))
        else $error("no reset on low supply");
    a_mr_low_reset: assert property (@(posedge clk) disable iff (!rstn)
        !sense.manualResetN ##1 !sense.manualResetN ##1 !sense.manualResetN
        |-> ##2 (resetOut == RST_HIGH))
        else $error("no reset on manual input");
    a_wdt_pulse: assert property (@(posedge clk) disable iff (!rstn)
        (WDT_PULSES && watchdogTimeout) |-> ##2 (resetOut == RST_HIGH))
        else $error("no reset on watchdog timeout");
    a_reset_min_hold: assert property (@(posedge clk) disable iff (!rstn)
        $fell(rstTrig) |-> rstAsserted_q[*8])
        else $error("reset released too early");

    // checks: seal and backup
    a_no_backup_vcc: assert property (@(posedge clk) disable iff (!rstn)
        vccOk |=> !onBatteryFlag)
        else $error("backup with supply above threshold");
    a_backup_sealed: assert property (@(posedge clk) disable iff (!rstn)
        $rose(railOnCell) |-> $past(sealed_q) && !$past(vccOk))
        else $error("rail on unsealed cell");
    a_seal_set: assert property (@(posedge clk) disable iff (!rstn)
        vccOk |=> sealed_q)
        else $error("seal latch not set");
    a_seal_clear: assert property (@(posedge clk) disable iff (!rstn)
        $fell(sealed_q) |-> $past(rearm_q) && !$past(vccOk))
        else $error("seal cleared without re-arm");

endmodule
`default_nettype wire

// ===== sbr_cpu_model.sv
// Purpose: processor-side model watching the supervisor reset output
// Assumes: reset polarity set by RST_HIGH
// Notes:   counts how often the processor is let out of reset
`default_nettype none
module sbr_cpu_model #(
    parameter bit RST_HIGH = 1'b0
) (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic resetIn,
    output var  int   releaseCnt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic inReset_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            inReset_q  <= 1'b1;
            releaseCnt <= 0;
        end else begin
            inReset_q <= (resetIn == RST_HIGH);
            if (inReset_q && resetIn != RST_HIGH) begin
                releaseCnt <= releaseCnt + 1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== sbr_battery_reset_tb.sv
// Purpose: self-checking bench for the supervisor battery/reset logic
// Assumes: short tick and window counts set at the instance
// Notes:   flag outputs are sampled on the falling edge, APB answers on the rising edge
`include "sbr_cfg.svh"
`default_nettype none
module sbr_battery_reset_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sbr_pkg::*;
    localparam int TC = 10, TT = 5, DT = 20, RT = 3;
    localparam int IRST = 0, IGOOD = 1, ILOAD = 2, IPF = 3, IBATT = 4, IRAIL = 5, IWDT = 6;
    localparam logic RON = 1'b0;
    logic         clk, rstn, wdt, err;
    sbr_apb_req_t apbReq;
    sbr_apb_rsp_t apbRsp;
    sbr_sense_t   sense;
    logic         resetOut, good, load, pfN, onBatt, rail, rstHi, errCap;
    logic [6:0]   outs;
    logic [31:0]  rd, rdCap;
    int           error_cnt, cmp_count, rlsCnt, n, m, doneCnt;
    assign outs = {rstHi, rail, onBatt, pfN, load, good, resetOut};

    sbr_battery_reset #(.TICK_CYC(TC), .TEST_TICKS(TT), .DAY_TICKS(DT), .RST_TICKS(RT))
    i_sbr_battery_reset (.clk(clk), .rstn(rstn), .apbReq(apbReq), .apbRsp(apbRsp),
        .sense(sense), .watchdogTimeout(wdt), .resetOut(resetOut), .batteryGoodFlag(good),
        .batteryTestLoadDrive(load), .powerFailFlagN(pfN), .onBatteryFlag(onBatt),
        .railOnCell(rail));
    // second build: high-active reset, watchdog pulses reset
    sbr_battery_reset #(.TICK_CYC(TC), .TEST_TICKS(TT), .DAY_TICKS(DT), .RST_TICKS(RT),
        .RST_HIGH(1'b1), .WDT_PULSES(1'b1))
    i_sbr_battery_reset_wdt (.clk(clk), .rstn(rstn), .apbReq(apbReq), .apbRsp(),
        .sense(sense), .watchdogTimeout(wdt), .resetOut(rstHi), .batteryGoodFlag(),
        .batteryTestLoadDrive(), .powerFailFlagN(), .onBatteryFlag(),
        .railOnCell());
    sbr_cpu_model #(.RST_HIGH(1'b0)) i_sbr_cpu_model (.clk(clk), .rstn(rstn),
        .resetIn(resetOut), .releaseCnt(rlsCnt));

    always #5 clk = ~clk;

    // answer taken at the very edge where the access completes
    always_ff @(posedge clk) begin
        if (apbReq.psel && apbReq.penable && apbRsp.pready) begin
            rdCap   <= apbRsp.prdata;
            errCap  <= apbRsp.pslverr;
            doneCnt <= doneCnt + 1;
        end
    end

    task automatic chk_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_time(input int got, input int lo, input int hi);
        cmp_count++;
        if (got < lo || got > hi) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h..%h", $time, got, lo, hi);
        end
    endtask
    // counts falling edges until the output reaches v, gives up after maxc
    task automatic wait_bit(input int idx, input logic v, input int maxc, output int cyc);
        cyc = 0;
        @(negedge clk);
        while (outs[idx] !== v && cyc < maxc) begin
            cyc++;
            @(negedge clk);
        end
        chk_bit(outs[idx], v);
    endtask
    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int start;
        start = doneCnt;
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge clk);
        apbReq.penable <= 1'b1;
        wait (doneCnt != start);
        rd = rdCap;
        err = errCap;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
        @(posedge clk);
    endtask
    task end_of_test;
        $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        $display("watchdog expired");
        end_of_test();
    end

    initial begin
        clk = 1'b0;
        rstn = 1'b0;
        wdt = 1'b0;
        apbReq = '0;
        sense = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        chk_bit(resetOut, RON);
        chk_bit(rstHi, 1'b1);
        wait_bit(ILOAD, 1'b1, 10, n);
        wait_bit(ILOAD, 1'b0, 80, n);
        chk_time(n, (TT - 1) * TC, TT * TC + 2);
        chk_bit(good, 1'b1);
        $display("power-up test done");
        @(posedge clk) sense.cellAboveTest <= 1'b0;
        wait_bit(ILOAD, 1'b1, 200, n);
        chk_time(n, (DT - TT - 1) * TC, (DT - TT + 1) * TC + 5);
        wait_bit(ILOAD, 1'b0, 80, n);
        chk_bit(good, 1'b0);
        @(posedge clk) sense.cellAboveTest <= 1'b1;
        apb(1'b1, `SBR_OFS_CTRL, 32'h0000_0001);
        wait_bit(ILOAD, 1'b1, 8, n);
        wait_bit(ILOAD, 1'b0, 80, n);
        chk_bit(good, 1'b1);
        $display("daily test done");
        @(posedge clk) wdt <= 1'b1;
        wait_bit(IWDT, 1'b1, 6, n);
        chk_bit(resetOut, ~RON);
        @(posedge clk) wdt <= 1'b0;
        wait_bit(IWDT, 1'b0, 80, n);
        chk_time(n, RT * TC, (RT + 2) * TC + 8);
        $display("watchdog pulse test done");
        @(posedge clk) sense.manualResetN <= 1'b0;
        sense.powerFailSense <= 1'b0;
        wait_bit(IRST, RON, 6, n);
        wait_bit(IPF, 1'b0, 6, n);
        @(posedge clk) sense.powerFailSense <= 1'b1;
        wait_bit(IPF, 1'b1, 6, n);
        @(posedge clk) sense.manualResetN <= 1'b1;
        wait_bit(IRST, ~RON, 80, n);
        chk_time(n, RT * TC, (RT + 2) * TC + 8);
        $display("manual reset test done");
        @(posedge clk) sense.vccAboveRst <= 1'b0;
        wait_bit(IRST, RON, 6, n);
        repeat (10) @(negedge clk);
        chk_bit(onBatt, 1'b0);
        @(posedge clk) sense.vccAboveRst <= 1'b1;
        fork
            wait_bit(IRST, ~RON, 80, n);
            wait_bit(ILOAD, 1'b1, 10, m);
        join
        chk_time(n, RT * TC, (RT + 2) * TC + 8);
        wait_bit(ILOAD, 1'b0, 80, n);
        $display("supply dip test done");
        @(posedge clk) sense.vccAboveBatt <= 1'b0;
        sense.cellAboveTest <= 1'b0;
        repeat (20) @(negedge clk);
        chk_bit(resetOut, ~RON);
        chk_bit(onBatt, 1'b0);
        @(posedge clk);
        apb(1'b0, `SBR_OFS_STATUS, 32'h0);
        chk_bit(rd[`SBR_ST_SEALED], 1'b1);
        apb(1'b0, 12'h008, 32'h0);
        chk_bit(err, 1'b1);
        chk_word(rd, 32'h0000_0000);
        apb(1'b1, `SBR_OFS_STATUS, 32'h0000_00FF);
        chk_bit(err, 1'b1);
        $display("register test done");
        sense.vccAboveRst <= 1'b0;
        sense.powerFailSense <= 1'b0;
        wait_bit(IBATT, 1'b1, 6, n);
        chk_bit(rail, 1'b1);
        chk_bit(good, 1'b0);
        chk_bit(load, 1'b0);
        chk_bit(pfN, 1'b0);
        @(posedge clk) sense.manualResetHv <= 1'b1;
        repeat (310) @(posedge clk);
        sense.manualResetHv <= 1'b0;
        sense.outRailLow <= 1'b1;
        repeat (5) @(posedge clk);
        sense.outRailLow <= 1'b0;
        wait_bit(IRAIL, 1'b0, 10, n);
        @(posedge clk);
        apb(1'b0, `SBR_OFS_STATUS, 32'h0);
        chk_bit(rd[`SBR_ST_SEALED], 1'b0);
        sense <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
        wait_bit(IRST, ~RON, 80, n);
        @(posedge clk);
        apb(1'b0, `SBR_OFS_STATUS, 32'h0);
        chk_bit(rd[`SBR_ST_SEALED], 1'b1);
        chk_word(rlsCnt, 32'h0000_0004);
        $display("backup and seal test done");
        end_of_test();
    end
endmodule
`default_nettype wire
